// [rtl/mda_pkg.sv]
// package: constants, special function register map and types of the data memory access block
// assumes: compiled before every other design file of the block
package mda_pkg;
   localparam int NSFR = 38;
   localparam int RAM_DEPTH = 256;
   localparam int STR_W = 3;
   localparam int PSEL_BIT = 0;
   localparam int BANK_HI = 4;
   localparam int BANK_LO = 3;
   localparam logic [7:0] UPPER_BASE = 8'h80;
   localparam logic [7:0] BITRAM_BASE = 8'h20;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [3:0] RD_EXTRA = 4'h1;
   localparam logic [3:0] WR_EXTRA = 4'h2;
   localparam logic [3:0] WR_MIN = 4'h1;

   // special function register addresses, slot order
   localparam logic [7:0] SFR_ADDR [NSFR] = '{
      8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89,
      8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h90, 8'h92, 8'h98, 8'h99, 8'h9A,
      8'h9B, 8'h9C, 8'h9D, 8'hA0, 8'hA8, 8'hA9, 8'hAA, 8'hB8, 8'hB9, 8'hBA,
      8'hBB, 8'hBF, 8'hC0, 8'hC8, 8'hD0, 8'hD8, 8'hE0, 8'hF0};
   // reset values, same slot order
   localparam logic [7:0] SFR_RST [NSFR] = '{
      8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hD9, 8'h00, 8'h00, 8'h03,
      8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   // slots used by the block's own logic
   localparam int IX_SP = 1;
   localparam int IX_DPL0 = 2;
   localparam int IX_DPH0 = 3;
   localparam int IX_POINTER1_LOW = 4;
   localparam int IX_POINTER1_HIGH = 5;
   localparam int IX_STRETCH = 14;
   localparam int IX_PSEL = 16;
   localparam int IX_PAGE = 31;
   localparam int IX_PSW = 34;
   localparam int IX_ACC = 36;
   localparam int IX_B = 37;

   typedef enum logic [3:0] {
      OP_DIR_RD = 4'h0, OP_DIR_WR = 4'h1, OP_IND_RD = 4'h2, OP_IND_WR = 4'h3,
      OP_REG_RD = 4'h4, OP_REG_WR = 4'h5, OP_BIT_RD = 4'h6, OP_BIT_WR = 4'h7,
      OP_PUSH = 4'h8, OP_POP = 4'h9, OP_PRIMARY_DATA_POINTER_LD = 4'hA, OP_PRIMARY_DATA_POINTER_INC = 4'hB,
      OP_XRD_RI = 4'hC, OP_XWR_RI = 4'hD, OP_XRD_DP = 4'hE, OP_XWR_DP = 4'hF
   } mda_op_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_XACT = 1'b1
   } mda_state_t;
endpackage

// [rtl/mda_iram.sv]
// internal data ram: 256 bytes, one write port, one asynchronous read port
// assumes: one writer per cycle; contents are undefined after power-up
`timescale 1ns/1ps
module mda_iram import mda_pkg::*; (
   // clock
   input wire logic ref_clk,
   // read
   input wire logic [7:0] raddr,
   output logic [7:0] rdata,
   // write
   input wire logic we,
   input wire logic [7:0] waddr,
   input wire logic [7:0] wdata
);
   logic [7:0] mem [RAM_DEPTH];

   // no reset: software initialises the ram, as with any sram macro
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];
endmodule

// [rtl/mda_xtime.sv]
// external data cycle widths for a given stretch value and direction
// assumes: stretch is held stable for the whole cycle by the caller
`timescale 1ns/1ps
module mda_xtime import mda_pkg::*; (
   // setting
   input wire logic [STR_W-1:0] stretch,
   input wire logic is_write,
   // widths in clock cycles
   output logic [3:0] addr_len,
   output logic [3:0] strobe_len
);
   logic [3:0] st4;

   assign st4 = {1'b0, stretch};
   assign addr_len = st4 + (is_write ? WR_EXTRA : RD_EXTRA);
   // write strobe never drops below one cycle
   assign strobe_len = !is_write ? st4 + RD_EXTRA : ((st4 < WR_MIN) ? WR_MIN : st4);
endmodule

// [rtl/mda_core.sv]
// data memory access block: internal ram, special function registers,
// register banks, bit space, dual data pointer and stretched external data cycles
// assumes: the instruction sequencer on the same clock issues one request per cycle,
// external data memory returns read data combinationally during the strobe
`timescale 1ns/1ps
module mda_core import mda_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // request from the instruction sequencer
   input wire logic req_valid,
   input wire mda_op_t req_op,
   input wire logic [7:0] req_addr,
   input wire logic [7:0] req_wdata,
   // answer
   output logic busy,
   output logic done,
   output logic [7:0] rd_data,
   // operands for the arithmetic unit
   output logic [7:0] acc_out,
   output logic [7:0] b_out,
   // external data memory
   output logic [15:0] ext_addr,
   output logic [7:0] ext_wdata,
   output logic ext_addr_valid,
   output logic ext_rd,
   output logic ext_wr,
   input wire logic [7:0] ext_rdata
);
   typedef struct packed {
      mda_state_t st;
      logic busy;
      logic done;
      logic xwr;
      logic ext_av;
      logic ext_rd;
      logic ext_wr;
      logic [STR_W-1:0] xst;
      logic [3:0] cnt;
      logic [15:0] ext_addr;
      logic [7:0] ext_wdata;
      logic [7:0] rd_data;
      logic [NSFR-1:0][7:0] special_function_register;
   } mda_regs_t;

   function automatic mda_regs_t reset_state();
      mda_regs_t r;
      r = '0;
      for (int i = 0; i < NSFR; i++) begin
         r.special_function_register[i] = SFR_RST[i];
      end
      return r;
   endfunction

   // returns {hit, slot}; used by both the read and the write path
   function automatic logic [6:0] sfr_find(input logic [7:0] a);
      logic [6:0] f;
      f = '0;
      for (int i = 0; i < NSFR; i++) begin
         if (SFR_ADDR[i] == a) begin
            f = {1'b1, 6'(i)};
         end
      end
      return f;
   endfunction

   localparam mda_regs_t Q_RST = reset_state();

   mda_regs_t q;
   mda_regs_t n;

   logic [7:0] ea;
   logic [7:0] ram_rdata;
   logic ram_we;
   logic [7:0] ram_wdata;
   logic [7:0] rbyte;
   logic [7:0] wbyte;
   logic [7:0] wr_val;
   logic wr_en;
   logic is_sfr;
   logic [6:0] found;
   logic [5:0] slot;
   logic [15:0] primary_data_pointer;
   logic [15:0] primary_data_pointer_inc;
   logic dsel;
   logic [1:0] bank;
   logic [2:0] bitpos;
   logic [3:0] alen;
   logic [3:0] slen;
   logic [3:0] cnt_nx;
   logic is_ri;

   mda_iram u_iram (
      .ref_clk(ref_clk),
      .raddr(ea),
      .rdata(ram_rdata),
      .we(ram_we),
      .waddr(ea),
      .wdata(ram_wdata)
   );

   // widths come from the stretch latched at cycle start
   mda_xtime u_xtime (
      .stretch(q.xst),
      .is_write(q.xwr),
      .addr_len(alen),
      .strobe_len(slen)
   );

   assign dsel = q.special_function_register[IX_PSEL][PSEL_BIT];
   assign primary_data_pointer = dsel ? {q.special_function_register[IX_POINTER1_HIGH], q.special_function_register[IX_POINTER1_LOW]} : {q.special_function_register[IX_DPH0], q.special_function_register[IX_DPL0]};
   assign primary_data_pointer_inc = primary_data_pointer + 16'h0001;
   assign bank = q.special_function_register[IX_PSW][BANK_HI:BANK_LO];
   assign bitpos = req_addr[2:0];
   assign is_ri = (req_op == OP_XRD_RI) || (req_op == OP_XWR_RI);

   // effective internal address of the request
   always_comb begin
      case (req_op)
         OP_REG_RD, OP_REG_WR: ea = {3'b000, bank, req_addr[2:0]};
         OP_XRD_RI, OP_XWR_RI: ea = {3'b000, bank, 2'b00, req_addr[0]};
         OP_BIT_RD, OP_BIT_WR: begin
            // bit space above 0x7F only lands on registers whose low three address bits are zero
            if (req_addr[7]) begin
               ea = {req_addr[7:3], 3'b000};
            end else begin
               ea = BITRAM_BASE + {4'h0, req_addr[6:3]};
            end
         end
         OP_PUSH: ea = q.special_function_register[IX_SP] + 8'h01;
         OP_POP: ea = q.special_function_register[IX_SP];
         default: ea = req_addr;
      endcase
   end

   // only direct and bit forms see registers in the upper half
   always_comb begin
      case (req_op)
         OP_DIR_RD, OP_DIR_WR, OP_BIT_RD, OP_BIT_WR: is_sfr = ea >= UPPER_BASE;
         default: is_sfr = 1'b0;
      endcase
   end

   assign found = sfr_find(ea);
   assign slot = found[5:0];
   assign rbyte = !is_sfr ? ram_rdata : (found[6] ? q.special_function_register[slot] : UNMAPPED_READ);
   assign wr_en = (req_op == OP_DIR_WR) || (req_op == OP_IND_WR) || (req_op == OP_REG_WR)
      || (req_op == OP_BIT_WR) || (req_op == OP_PUSH);

   always_comb begin
      wbyte = rbyte;
      wbyte[bitpos] = req_wdata[0];
      wr_val = (req_op == OP_BIT_WR) ? wbyte : req_wdata;
   end

   always_comb begin
      n = q;
      n.done = 1'b0;
      ram_we = 1'b0;
      ram_wdata = wr_val;
      cnt_nx = q.cnt + 4'h1;
      case (q.st)
         ST_IDLE: begin
            if (req_valid) begin
               n.done = 1'b1;
               n.rd_data = rbyte;
               if (wr_en) begin
                  if (!is_sfr) begin
                     ram_we = 1'b1;
                  end else if (found[6]) begin
                     n.special_function_register[slot] = wr_val;
                  end
               end
               case (req_op)
                  OP_BIT_RD: n.rd_data = {7'h00, rbyte[bitpos]};
                  OP_PUSH: n.special_function_register[IX_SP] = ea;
                  OP_POP: n.special_function_register[IX_SP] = q.special_function_register[IX_SP] - 8'h01;
                  OP_PRIMARY_DATA_POINTER_LD, OP_PRIMARY_DATA_POINTER_INC: begin
                     if (dsel) begin
                        {n.special_function_register[IX_POINTER1_HIGH], n.special_function_register[IX_POINTER1_LOW]} =
                           (req_op == OP_PRIMARY_DATA_POINTER_LD) ? {req_addr, req_wdata} : primary_data_pointer_inc;
                     end else begin
                        {n.special_function_register[IX_DPH0], n.special_function_register[IX_DPL0]} =
                           (req_op == OP_PRIMARY_DATA_POINTER_LD) ? {req_addr, req_wdata} : primary_data_pointer_inc;
                     end
                  end
                  OP_XRD_RI, OP_XWR_RI, OP_XRD_DP, OP_XWR_DP: begin
                     n.done = 1'b0;
                     n.st = ST_XACT;
                     n.busy = 1'b1;
                     // latched once, so a later write cannot bend a running cycle
                     n.xst = q.special_function_register[IX_STRETCH][STR_W-1:0];
                     n.xwr = (req_op == OP_XWR_RI) || (req_op == OP_XWR_DP);
                     n.ext_addr = is_ri ? {q.special_function_register[IX_PAGE], ram_rdata} : primary_data_pointer;
                     n.ext_wdata = q.special_function_register[IX_ACC];
                     n.ext_av = 1'b1;
                     n.ext_rd = !n.xwr;
                     n.ext_wr = 1'b0;
                     n.cnt = 4'h0;
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_XACT: begin
            n.cnt = cnt_nx;
            n.ext_wr = q.xwr && (cnt_nx <= slen);
            if (q.cnt == alen - 4'h1) begin
               n.st = ST_IDLE;
               n.busy = 1'b0;
               n.ext_av = 1'b0;
               n.ext_rd = 1'b0;
               n.ext_wr = 1'b0;
               n.done = 1'b1;
               if (!q.xwr) begin
                  n.special_function_register[IX_ACC] = ext_rdata;
                  n.rd_data = ext_rdata;
               end
            end
         end
         default: n = Q_RST;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= Q_RST;
      end else begin
         q <= n;
      end
   end

   assign busy = q.busy;
   assign done = q.done;
   assign rd_data = q.rd_data;
   assign acc_out = q.special_function_register[IX_ACC];
   assign b_out = q.special_function_register[IX_B];
   assign ext_addr = q.ext_addr;
   assign ext_wdata = q.ext_wdata;
   assign ext_addr_valid = q.ext_av;
   assign ext_rd = q.ext_rd;
   assign ext_wr = q.ext_wr;

   // checks: widths of external strobes are counted by helper counters
   logic [3:0] h_av;
   logic [3:0] h_rd;
   logic [3:0] h_wr;
   logic idle_req;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         h_av <= 4'h0;
         h_rd <= 4'h0;
         h_wr <= 4'h0;
      end else begin
         h_av <= q.ext_av ? h_av + 4'h1 : 4'h0;
         h_rd <= q.ext_rd ? h_rd + 4'h1 : 4'h0;
         h_wr <= q.ext_wr ? h_wr + 4'h1 : 4'h0;
      end
   end

   assign idle_req = req_valid && (q.st == ST_IDLE);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   AST_RD_WIDTH: assert property ($fell(q.ext_rd) |-> h_rd == {1'b0, q.xst} + RD_EXTRA)
      else $error("read strobe width differs from stretch plus one");
   AST_RD_ADDR: assert property ($fell(q.ext_av) && !q.xwr |-> h_av == {1'b0, q.xst} + RD_EXTRA)
      else $error("read address phase width differs from stretch plus one");
   AST_WR_ADDR: assert property ($fell(q.ext_av) && q.xwr |-> h_av == {1'b0, q.xst} + WR_EXTRA)
      else $error("write address phase width differs from stretch plus two");
   AST_WR_WIDTH: assert property ($fell(q.ext_wr) |->
      h_wr == ((q.xst <= STR_W'(1)) ? WR_MIN : {1'b0, q.xst}))
      else $error("write strobe width wrong");
   AST_STRETCH_HOLD: assert property (q.ext_av && $past(q.ext_av) |-> $stable(q.xst))
      else $error("stretch changed inside an external cycle");
   AST_STRETCH_PICK: assert property (idle_req && req_op == OP_XRD_DP |=>
      q.xst == $past(q.special_function_register[IX_STRETCH][STR_W-1:0]))
      else $error("stretch not taken from low control bits");
   AST_PAGED_ADDR: assert property (idle_req && req_op == OP_XRD_RI |=>
      q.ext_addr == {$past(q.special_function_register[IX_PAGE]), $past(ram_rdata)} && q.ext_rd)
      else $error("paged external address wrong");
   AST_PTR_ADDR: assert property (idle_req && req_op == OP_XWR_DP |=>
      q.ext_addr == $past(primary_data_pointer) && q.ext_wdata == $past(q.special_function_register[IX_ACC]))
      else $error("pointer external address or data wrong");
   AST_RD_ACC: assert property ($fell(q.ext_rd) |-> q.special_function_register[IX_ACC] == $past(ext_rdata) && q.done)
      else $error("accumulator not loaded by external read");
   AST_PTR_SEL: assert property (idle_req && req_op == OP_PRIMARY_DATA_POINTER_INC && dsel |=>
      {q.special_function_register[IX_POINTER1_HIGH], q.special_function_register[IX_POINTER1_LOW]} == $past(primary_data_pointer) + 16'h0001
      && $stable({q.special_function_register[IX_DPH0], q.special_function_register[IX_DPL0]}))
      else $error("increment hit the wrong pointer");
   AST_PUSH_PRE: assert property (idle_req && req_op == OP_PUSH |->
      ea == q.special_function_register[IX_SP] + 8'h01 ##1 q.special_function_register[IX_SP] == $past(ea))
      else $error("push did not pre-increment the stack pointer");
   AST_IND_UPPER: assert property (idle_req && req_op == OP_IND_WR && req_addr[7] |=>
      $stable(q.special_function_register))
      else $error("indirect write reached a register");
   AST_UNMAPPED_WR: assert property (idle_req && req_op == OP_DIR_WR && req_addr[7]
      && !found[6] |=> $stable(q.special_function_register))
      else $error("write to unmapped register changed state");

   COV_PAGED_RD: cover property (idle_req && req_op == OP_XRD_RI ##[1:10] $fell(q.ext_rd));
   COV_SLOW_WR: cover property ($fell(q.ext_wr) && q.xst == 3'h7);
   COV_PTR1_INC: cover property (idle_req && req_op == OP_PRIMARY_DATA_POINTER_INC && dsel);
   COV_BANK3: cover property (idle_req && req_op == OP_REG_WR && bank == 2'b11);
endmodule

// [test/mda_xram_model.sv]
// partner: external data ram seen by the external move port of the core
// assumes: address, data and strobes come registered from the core on ref_clk
`timescale 1ns/1ps
module mda_xram_model (
   // clock
   input wire logic ref_clk,
   // external data port
   input wire logic [15:0] ext_addr,
   input wire logic [7:0] ext_wdata,
   input wire logic ext_rd,
   input wire logic ext_wr,
   output logic [7:0] ext_rdata
);
   logic [7:0] mem [65536];
   logic [7:0] last = 8'h00;
   // outside a read the bus shows the inverse of its last value, never a kept copy
   assign ext_rdata = ext_rd ? mem[ext_addr] : ~last;
   always @(posedge ref_clk) begin
      if (ext_wr)
         mem[ext_addr] <= ext_wdata;
      if (ext_rd)
         last <= mem[ext_addr];
   end
endmodule

// [test/test_mda_core.sv]
// testbench: drives the request port of the core and checks it against a queue-free behavioural model
// assumes: mda_pkg is compiled first and the external ram model sits on the external port
`timescale 1ns/1ps
module test_mda_core;
   import mda_pkg::*;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic req_valid = 1'b0;
   mda_op_t req_op = OP_DIR_RD;
   logic [7:0] req_addr = 8'h00;
   logic [7:0] req_wdata = 8'h00;
   logic busy, done, ext_addr_valid, ext_rd, ext_wr;
   logic [7:0] rd_data, acc_out, b_out, ext_wdata, ext_rdata;
   logic [15:0] ext_addr;
   int failures = 0;
   int tests_run = 0;
   int n_av, n_rd, n_wr, n_bz;
   logic [7:0] m_ram [256];
   logic [7:0] m_sfr [256];
   logic [7:0] m_x [int];
   logic [7:0] d, b, by, v;

   mda_core u_mda_core (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .done(done), .rd_data(rd_data),
      .acc_out(acc_out), .b_out(b_out), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .ext_addr_valid(ext_addr_valid), .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_rdata(ext_rdata));
   mda_xram_model u_mda_xram_model (.ref_clk(ref_clk), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_rdata(ext_rdata));

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   // strobes are registered, so each edge sees one whole cycle
   always @(posedge ref_clk) begin
      n_av += int'(ext_addr_valid === 1'b1);
      n_rd += int'(ext_rd === 1'b1);
      n_wr += int'(ext_wr === 1'b1);
      n_bz += int'(busy === 1'b1);
   end

   function automatic bit mapped(logic [7:0] a);
      foreach (SFR_ADDR[i])
         if (SFR_ADDR[i] == a)
            return 1'b1;
      return 1'b0;
   endfunction
   function automatic logic [7:0] dread(logic [7:0] a);
      if (a < 8'h80)
         return m_ram[a];
      return mapped(a) ? m_sfr[a] : UNMAPPED_READ;
   endfunction

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic op(mda_op_t o, logic [7:0] a, logic [7:0] w);
      int n;
      n = 0;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_op <= o;
      req_addr <= a;
      req_wdata <= w;
      // done stands for one cycle only, so look right after every edge from the taking edge on
      do begin
         @(posedge ref_clk);
         req_valid <= 1'b0;
         #1;
         n++;
      end while (done !== 1'b1 && n < 40);
      if (done !== 1'b1) begin
         failures++;
         $display("[ERR] done expected 1 seen %b", done);
         wrap_up();
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] w);
      op(OP_DIR_WR, a, w);
      if (a < 8'h80)
         m_ram[a] = w;
      else if (mapped(a))
         m_sfr[a] = w;
   endtask
   task automatic rd(logic [7:0] a);
      op(OP_DIR_RD, a, 8'h00);
      chk("direct read", 16'(dread(a)), 16'(rd_data));
   endtask
   task automatic ld(logic [7:0] hi, logic [7:0] lo);
      op(OP_PRIMARY_DATA_POINTER_LD, hi, lo);
      m_sfr[m_sfr[8'h92][0] ? 8'h85 : 8'h83] = hi;
      m_sfr[m_sfr[8'h92][0] ? 8'h84 : 8'h82] = lo;
   endtask
   task automatic do_reset;
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      foreach (SFR_ADDR[i])
         m_sfr[SFR_ADDR[i]] = SFR_RST[i];
      chk("acc_out", 16'h0000, 16'(acc_out));
      foreach (SFR_ADDR[i])
         rd(SFR_ADDR[i]);
      $display("test reset done");
   endtask
   task automatic xop(mda_op_t o, logic [7:0] a);
      int s;
      logic [15:0] xa;
      logic [7:0] base;
      s = int'(m_sfr[8'h8E][2:0]);
      base = {3'b000, m_sfr[8'hD0][4:3], 3'b000};
      if (o == OP_XRD_RI || o == OP_XWR_RI)
         xa = {m_sfr[8'hBF], m_ram[base + {7'h00, a[0]}]};
      else if (m_sfr[8'h92][0])
         xa = {m_sfr[8'h85], m_sfr[8'h84]};
      else
         xa = {m_sfr[8'h83], m_sfr[8'h82]};
      n_av = 0;
      n_rd = 0;
      n_wr = 0;
      n_bz = 0;
      op(o, a, 8'h00);
      chk("ext_addr", xa, ext_addr);
      if (o == OP_XWR_RI || o == OP_XWR_DP) begin
         m_x[int'(xa)] = m_sfr[8'hE0];
         chk("ext_wdata", 16'(m_sfr[8'hE0]), 16'(ext_wdata));
         chk("write addr width", 16'(s + 2), 16'(n_av));
         chk("write strobe width", 16'(s < 2 ? 1 : s), 16'(n_wr));
         chk("read strobe in write", 16'h0000, 16'(n_rd));
         chk("write busy width", 16'(s + 2), 16'(n_bz));
      end else begin
         m_sfr[8'hE0] = m_x[int'(xa)];
         chk("read addr width", 16'(s + 1), 16'(n_av));
         chk("read strobe width", 16'(s + 1), 16'(n_rd));
         chk("read busy width", 16'(s + 1), 16'(n_bz));
         chk("acc_out", 16'(m_sfr[8'hE0]), 16'(acc_out));
         chk("rd_data", 16'(m_sfr[8'hE0]), 16'(rd_data));
      end
   endtask

   initial begin
      void'($urandom(32'hD6370DAD));
      do_reset();
      d = 8'($urandom);
      op(OP_PUSH, 8'h00, d);
      m_ram[8'h08] = d;
      m_sfr[8'h81] = 8'h08;
      rd(8'h08);
      rd(8'h81);
      op(OP_POP, 8'h00, 8'h00);
      chk("pop data", 16'(d), 16'(rd_data));
      m_sfr[8'h81] = 8'h07;
      rd(8'h81);
      $display("test stack done");
      for (int a = 128; a < 256; a++) begin
         wr(8'(a), 8'($urandom));
         rd(8'(a));
      end
      chk("b_out", 16'(m_sfr[8'hF0]), 16'(b_out));
      chk("acc_out", 16'(m_sfr[8'hE0]), 16'(acc_out));
      $display("test register map done");
      for (int k = 0; k < 24; k++) begin
         b = 8'($urandom);
         d = 8'($urandom);
         op(OP_IND_WR, b, d);
         m_ram[b] = d;
         op(OP_IND_RD, b, 8'h00);
         chk("indirect read", 16'(d), 16'(rd_data));
         rd(b);
      end
      $display("test indirect done");
      for (int k = 0; k < 4; k++) begin
         wr(8'hD0, 8'(k << 3));
         for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            op(OP_REG_WR, 8'(i), d);
            m_ram[8'(k * 8 + i)] = d;
            op(OP_REG_RD, 8'(i), 8'h00);
            chk("register read", 16'(d), 16'(rd_data));
            rd(8'(k * 8 + i));
         end
      end
      $display("test banks done");
      for (int i = 0; i < 16; i++)
         wr(8'h20 + 8'(i), 8'($urandom));
      for (int k = 0; k < 48; k++) begin
         b = 8'($urandom);
         d = 8'($urandom & 1);
         by = b < 8'h80 ? 8'h20 + {4'h0, b[6:3]} : {b[7:3], 3'b000};
         op(OP_BIT_WR, b, d);
         if (by < 8'h80)
            m_ram[by][b[2:0]] = d[0];
         else if (mapped(by))
            m_sfr[by][b[2:0]] = d[0];
         op(OP_BIT_RD, b, 8'h00);
         v = dread(by);
         chk("bit read", {15'h0000, v[b[2:0]]}, 16'(rd_data));
         rd(by);
      end
      $display("test bits done");
      for (int k = 0; k < 2; k++) begin
         wr(8'h92, 8'(k));
         ld(8'($urandom), 8'hFF);
         op(OP_PRIMARY_DATA_POINTER_INC, 8'h00, 8'h00);
         {m_sfr[8'h83 + 8'(k * 2)], m_sfr[8'h82 + 8'(k * 2)]} =
            {m_sfr[8'h83 + 8'(k * 2)], m_sfr[8'h82 + 8'(k * 2)]} + 16'h0001;
         for (int a = 8'h82; a < 8'h86; a++)
            rd(8'(a));
      end
      $display("test pointers done");
      for (int s = 0; s < 8; s++) begin
         wr(8'h8E, {5'($urandom), 3'(s)});
         wr(8'h92, 8'($urandom & 1));
         ld(8'($urandom), 8'($urandom));
         wr(8'hE0, 8'($urandom));
         xop(OP_XWR_DP, 8'h00);
         wr(8'hE0, 8'($urandom));
         xop(OP_XRD_DP, 8'h00);
         wr(8'hBF, 8'($urandom));
         wr(8'hD0, 8'($urandom & 8'h18));
         b = 8'($urandom & 1);
         op(OP_REG_WR, b, 8'($urandom));
         m_ram[{3'b000, m_sfr[8'hD0][4:3], 3'b000} + b] = req_wdata;
         wr(8'hE0, 8'($urandom));
         xop(OP_XWR_RI, b);
         wr(8'hE0, 8'($urandom));
         xop(OP_XRD_RI, b);
      end
      $display("test external moves done");
      do_reset();
      wrap_up();
   end
endmodule
